/* File: src/shi_pkg.sv */
// constants and types for the serial host interface
package shi_pkg;
    localparam int unsigned WF_DEPTH     = 4;
    localparam int unsigned RF_DEPTH     = 20;
    localparam int unsigned BYTE_BITS    = 8;
    // command register fields
    localparam int unsigned CMD_RST_BIT  = 7;
    localparam int unsigned CMD_VAL_BIT  = 6;
    localparam int unsigned CMD_MODE_HI  = 5;
    localparam int unsigned CMD_MODE_LO  = 4;
    // status register fields
    localparam int unsigned ST_WFULL_BIT = 7;
    localparam int unsigned ST_REMP_BIT  = 6;
    localparam int unsigned ST_WEMP_BIT  = 5;
    localparam int unsigned ST_IRQ_BIT   = 4;
    // reset values, software mode codes and last bit index
    localparam logic [7:0]  CMD_RST_VAL  = 8'h80;
    localparam logic [7:0]  SSB_RST_VAL  = 8'h80;
    localparam logic [1:0]  SW_PIN_CTRL  = 2'h0;
    localparam logic [1:0]  SW_DWRITE    = 2'h1;
    localparam logic [1:0]  SW_DREAD     = 2'h2;
    localparam logic [1:0]  SW_SREAD     = 2'h3;
    localparam logic [2:0]  BIT_LAST     = 3'h7;

    typedef enum logic [1:0] {
        SHI_DWRITE,
        SHI_DREAD,
        SHI_CWRITE,
        SHI_SREAD
    } shi_mode_t;
endpackage

/* File: src/shi_top.sv */
// serial host interface: link shifter, fifos, command and status registers
`timescale 1ns/1ps

// Functional notes
// - write fifo holds four bytes of transmit data and command parameters
// - read fifo holds twenty received bytes, drained byte by byte by host
// - command bit 7 one enters reset mode, zero leaves it while reset pin high
// - command code acted on only when command bit 6 is one
// - command bits 3..0 carry the communication control command code
// - status bit 7 reads one while write fifo is full
// - status bit 6 reads one while read fifo is empty
// - status bit 5 reads one while write fifo is empty
// - status bit 4 shows pending interrupt, cleared by status access
// - status bits 3..0 present latest communication return code
// - data write samples input on rising clock, msb first, eight bits
// - data read shifts fifo byte out on falling clock, msb first
// - command write captures input into command register on rising clock
// - status read drives status out on falling clock, msb first
// - with mode bits zero, the two mode pins select the access mode
// - with pins command/write, command bits 5..4 select the mode
// - after one software-mode byte, return to pin-controlled command write
// - low reset pin enters reset; leaving needs pin high and bit 7 zero
// - with pin high, bit 7 writes enter and leave reset mode
// - leaving reset, slave status byte reads 8'h80
// - leaving reset, both fifos empty and reception disabled
// - commands execute only while the bus is in standby
module shi_top
    import shi_pkg::*;
(
    // system
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    // serial link
    input  wire logic       i_sck,
    input  wire logic       i_si,
    input  wire logic       i_cs_n,
    input  wire logic       i_cd,
    input  wire logic       i_rw,
    input  wire logic       i_reset_pin_n,
    output logic            o_so,
    output logic            o_so_oe,
    // protocol layer side
    input  wire logic       i_rx_valid,
    input  wire logic [7:0] i_rx_data,
    output logic            o_rx_ready,
    input  wire logic       i_tx_pop,
    output logic            o_tx_valid,
    output logic [7:0]      o_tx_data,
    input  wire logic       i_bus_standby,
    input  wire logic       i_irq_event,
    input  wire logic       i_ret_valid,
    input  wire logic [3:0] i_ret_code,
    output logic            o_cmd_valid,
    output logic [3:0]      o_cmd_code,
    output logic            o_reset_mode,
    output logic            o_rx_enable,
    output logic [7:0]      o_slave_status
);
    import shi_pkg::*;

    // ---------------- link domain (serial clock) ----------------
    // bit counter and shifters run only while selected; the host stops sck
    // between frames, so byte completion is flagged by a toggle
    logic [2:0] lk_cnt_r;
    logic [2:0] lk_cnt_nxt;
    logic [7:0] lk_sh_r;
    logic [7:0] lk_sh_nxt;
    logic       lk_tog_r;
    logic       lk_tog_nxt;
    logic [7:0] lk_byte_r;
    logic [7:0] lk_byte_nxt;
    logic [1:0] lk_kind_r;
    logic [1:0] lk_kind_nxt;
    logic [7:0] lk_out_r;
    logic [2:0] lk_ocnt_r;
    logic       lk_so_r;
    logic [2:0] lk_ocnt_nxt;
    logic       lk_so_nxt;

    shi_mode_t  mode;
    logic [7:0] load_byte;
    logic [7:0] cmd_r;

    always_comb begin
        lk_cnt_nxt  = lk_cnt_r + 3'h1;
        lk_sh_nxt   = {lk_sh_r[6:0], i_si};
        lk_tog_nxt  = lk_tog_r;
        lk_byte_nxt = lk_byte_r;
        lk_kind_nxt = lk_kind_r;
        if (lk_cnt_r == BIT_LAST) begin
            lk_tog_nxt  = ~lk_tog_r;
            lk_byte_nxt = {lk_sh_r[6:0], i_si};
            lk_kind_nxt = mode;
        end
    end

    // i_cs_n acts as the frame signal: deselect clears the bit counter
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            lk_cnt_r <= 3'h0;
            lk_sh_r  <= 8'h00;
        end else begin
            lk_cnt_r <= lk_cnt_nxt;
            lk_sh_r  <= lk_sh_nxt;
        end
    end

    always_ff @(posedge i_sck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lk_tog_r  <= 1'b0;
            lk_byte_r <= 8'h00;
            lk_kind_r <= 2'h0;
        end else begin
            lk_tog_r  <= lk_tog_nxt;
            lk_byte_r <= lk_byte_nxt;
            lk_kind_r <= lk_kind_nxt;
        end
    end

    // read side: msb is presented on the first falling edge after select
    always_comb begin
        lk_ocnt_nxt = lk_ocnt_r + 3'h1;
        lk_so_nxt   = lk_out_r[3'h7 - lk_ocnt_r];
    end

    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            lk_ocnt_r <= 3'h0;
            lk_so_r   <= 1'b0;
        end else begin
            lk_ocnt_r <= lk_ocnt_nxt;
            lk_so_r   <= lk_so_nxt;
        end
    end

    // load byte is quasi-static while cs is high; sampled at select
    always_ff @(negedge i_cs_n or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lk_out_r <= 8'h00;
        end else begin
            lk_out_r <= load_byte;
        end
    end

    assign o_so    = lk_so_r;
    assign o_so_oe = ~i_cs_n & (mode == SHI_DREAD || mode == SHI_SREAD);

    // ---------------- system domain ----------------
    logic [2:0] tog_s_r;
    logic [2:0] tog_s_nxt;
    logic [2:0] cs_s_r;
    logic [2:0] cs_s_nxt;
    logic [1:0] rp_s_r;
    logic [1:0] rp_s_nxt;
    logic       byte_done;
    logic       desel_edge;
    shi_mode_t  kind;

    always_comb begin
        tog_s_nxt = {tog_s_r[1:0], lk_tog_r};
        cs_s_nxt  = {cs_s_r[1:0], i_cs_n};
        rp_s_nxt  = {rp_s_r[0], i_reset_pin_n};
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tog_s_r <= 3'h0;
            cs_s_r  <= 3'h7;
            rp_s_r  <= 2'h0;
        end else begin
            tog_s_r <= tog_s_nxt;
            cs_s_r  <= cs_s_nxt;
            rp_s_r  <= rp_s_nxt;
        end
    end

    // kind and byte are stable: they changed with the toggle, two sys edges before byte_done
    assign byte_done  = tog_s_r[2] ^ tog_s_r[1];
    assign kind       = shi_mode_t'(lk_kind_r);
    // edge taken past the second stage only, never from the first flop
    assign desel_edge = cs_s_r[1] & ~cs_s_r[2];

    // fifos and registers
    logic [7:0] wf_mem_r [WF_DEPTH];
    logic [7:0] wf_mem_nxt [WF_DEPTH];
    logic [7:0] rf_mem_r [RF_DEPTH];
    logic [7:0] rf_mem_nxt [RF_DEPTH];
    logic [2:0] wf_cnt_r;
    logic [2:0] wf_cnt_nxt;
    logic [4:0] rf_cnt_r;
    logic [4:0] rf_cnt_nxt;
    logic [7:0] cmd_nxt;
    logic       rstm_r;
    logic       rstm_nxt;
    logic       irq_r;
    logic       irq_nxt;
    logic [3:0] ret_r;
    logic [3:0] ret_nxt;
    logic       sw_used_r;
    logic       sw_used_nxt;
    logic       cmd_pend_r;
    logic       cmd_pend_nxt;
    logic       cmd_fire;
    logic       rxen_r;
    logic       rxen_nxt;
    logic [7:0] status;
    logic       wf_full;
    logic       rf_empty;
    logic       wf_empty;
    logic       wf_push;
    logic       rf_pop;
    logic       rf_push;

    assign wf_full  = (wf_cnt_r == 3'(WF_DEPTH));
    assign wf_empty = (wf_cnt_r == 3'h0);
    assign rf_empty = (rf_cnt_r == 5'h00);
    assign status   = {wf_full, rf_empty, wf_empty, irq_r, ret_r};

    // software mode applies only with pins at command/write and not yet used
    always_comb begin
        unique case ({i_cd, i_rw})
            2'b00: mode = SHI_DWRITE;
            2'b01: mode = SHI_DREAD;
            2'b10: mode = SHI_CWRITE;
            2'b11: mode = SHI_SREAD;
        endcase
        if (i_cd && !i_rw && !sw_used_r) begin
            unique case (cmd_r[CMD_MODE_HI:CMD_MODE_LO])
                SW_DWRITE:   mode = SHI_DWRITE;
                SW_DREAD:    mode = SHI_DREAD;
                SW_SREAD:    mode = SHI_SREAD;
                SW_PIN_CTRL: mode = SHI_CWRITE;
            endcase
        end
    end

    assign load_byte = (mode == SHI_SREAD) ? status : rf_mem_r[0];

    assign wf_push = byte_done && kind == SHI_DWRITE && !wf_full && !rstm_r;
    assign rf_pop  = byte_done && kind == SHI_DREAD && !rf_empty;
    assign rf_push = i_rx_valid && o_rx_ready;
    assign cmd_fire = cmd_pend_r && i_bus_standby && !rstm_r;

    always_comb begin
        wf_mem_nxt   = wf_mem_r;
        rf_mem_nxt   = rf_mem_r;
        wf_cnt_nxt   = wf_cnt_r;
        rf_cnt_nxt   = rf_cnt_r;
        cmd_nxt      = cmd_r;
        rstm_nxt     = rstm_r;
        irq_nxt      = irq_r;
        ret_nxt      = ret_r;
        sw_used_nxt  = sw_used_r;
        cmd_pend_nxt = cmd_pend_r & ~cmd_fire;
        rxen_nxt     = rxen_r;
        // write fifo: protocol pop shifts down, host push appends
        if (i_tx_pop && !wf_empty) begin
            for (int i = 0; i < WF_DEPTH - 1; i++) begin
                wf_mem_nxt[i] = wf_mem_r[i + 1];
            end
            wf_cnt_nxt = wf_cnt_r - 3'h1;
        end
        if (wf_push) begin
            wf_mem_nxt[wf_cnt_nxt[1:0]] = lk_byte_r;
            wf_cnt_nxt             = wf_cnt_nxt + 3'h1;
        end
        if (rf_pop) begin
            for (int i = 0; i < RF_DEPTH - 1; i++) begin
                rf_mem_nxt[i] = rf_mem_r[i + 1];
            end
            rf_cnt_nxt = rf_cnt_r - 5'h01;
        end
        if (rf_push) begin
            rf_mem_nxt[rf_cnt_nxt] = i_rx_data;
            rf_cnt_nxt             = rf_cnt_nxt + 5'h01;
        end
        if (byte_done && kind == SHI_CWRITE) begin
            cmd_nxt      = lk_byte_r;
            sw_used_nxt  = 1'b0;
            cmd_pend_nxt = lk_byte_r[CMD_VAL_BIT];
            if (lk_byte_r[CMD_RST_BIT]) begin
                rstm_nxt = 1'b1;
            end else if (rp_s_r[1]) begin
                rstm_nxt = 1'b0;
            end
        end else if (byte_done) begin
            sw_used_nxt = 1'b1;
        end
        // a new event in the clearing cycle wins over the clear
        if (byte_done && kind == SHI_SREAD) begin
            irq_nxt = 1'b0;
        end
        if (i_irq_event) begin
            irq_nxt = 1'b1;
        end
        if (i_ret_valid) begin
            ret_nxt = i_ret_code;
        end
        if (!rp_s_r[1]) begin
            rstm_nxt = 1'b1;
        end
        if (rstm_nxt) begin
            wf_cnt_nxt   = 3'h0;
            rf_cnt_nxt   = 5'h00;
            rxen_nxt     = 1'b0;
            cmd_pend_nxt = 1'b0;
        end
        if (desel_edge && sw_used_r) begin
            sw_used_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wf_cnt_r   <= 3'h0;
            rf_cnt_r   <= 5'h00;
            cmd_r      <= CMD_RST_VAL;
            rstm_r     <= 1'b1;
            irq_r      <= 1'b0;
            ret_r      <= 4'h0;
            sw_used_r  <= 1'b0;
            cmd_pend_r <= 1'b0;
            rxen_r     <= 1'b0;
            for (int i = 0; i < WF_DEPTH; i++) begin
                wf_mem_r[i] <= 8'h00;
            end
            for (int i = 0; i < RF_DEPTH; i++) begin
                rf_mem_r[i] <= 8'h00;
            end
        end else begin
            wf_cnt_r   <= wf_cnt_nxt;
            rf_cnt_r   <= rf_cnt_nxt;
            cmd_r      <= cmd_nxt;
            rstm_r     <= rstm_nxt;
            irq_r      <= irq_nxt;
            ret_r      <= ret_nxt;
            sw_used_r  <= sw_used_nxt;
            cmd_pend_r <= cmd_pend_nxt;
            rxen_r     <= rxen_nxt;
            wf_mem_r   <= wf_mem_nxt;
            rf_mem_r   <= rf_mem_nxt;
        end
    end

    // frame acknowledge is gated outside by o_rx_enable; fifo takes what was acked
    assign o_rx_ready     = !rstm_r && (rf_cnt_r != 5'(RF_DEPTH));
    assign o_tx_valid     = !wf_empty;
    assign o_tx_data      = wf_mem_r[0];
    assign o_cmd_valid    = cmd_fire;
    assign o_cmd_code     = cmd_r[3:0];
    assign o_reset_mode   = rstm_r;
    assign o_rx_enable    = rxen_r;
    assign o_slave_status = SSB_RST_VAL;

endmodule

/* File: tb/shi_host_model.sv */
// host side model driving the three-wire link and the mode pins
`timescale 1ns/1ps
module shi_host_model (
    // link input
    input  wire logic i_so,
    // link and pin outputs
    output logic      o_sck,
    output logic      o_si,
    output logic      o_cs_n,
    output logic      o_cd,
    output logic      o_rw,
    output logic      o_reset_pin_n
);
    initial begin
        {o_sck, o_si, o_cs_n, o_cd, o_rw} = 5'h1f;
        o_reset_pin_n = 1'b0;
    end
    task automatic pin(input logic v);
        o_reset_pin_n = v;
    endtask
    // one byte, msb first; sck stands high outside the frame
    task automatic xfer(input logic c, input logic r, input logic [7:0] d,
                        output logic [7:0] q);
        o_cd = c;
        o_rw = r;
        #20;
        o_cs_n = 1'b0;
        #62.5;
        for (int i = 7; i >= 0; i--) begin
            o_sck = 1'b0;
            o_si = d[i];
            #62.5;
            o_sck = 1'b1;
            q[i] = i_so;
            #62.5;
        end
        o_cs_n = 1'b1;
        o_si = ~o_si;
        #300;
    endtask
endmodule

/* File: tb/shi_top_sva.sv */
// concurrent checks on the serial host interface ports
`timescale 1ns/1ps
module shi_top_sva (
    // system
    input wire logic       i_clk_sys,
    input wire logic       i_rst_n,
    // link pins
    input wire logic       i_cs_n,
    input wire logic       i_cd,
    input wire logic       i_rw,
    input wire logic       i_reset_pin_n,
    input wire logic       o_so_oe,
    // protocol side
    input wire logic       i_bus_standby,
    input wire logic       o_tx_valid,
    input wire logic       o_cmd_valid,
    input wire logic       o_reset_mode,
    input wire logic       o_rx_enable,
    input wire logic [7:0] o_slave_status
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    a_oe_no_select: assert property (i_cs_n |-> !o_so_oe)
        else $error("so enabled without select");
    a_oe_pin_read: assert property ((!i_cs_n && !i_cd && i_rw && !o_reset_mode) |-> o_so_oe)
        else $error("so not enabled in data read");
    a_cmd_standby: assert property (o_cmd_valid |-> i_bus_standby)
        else $error("command ran off standby");
    a_cmd_pulse: assert property (o_cmd_valid |=> !o_cmd_valid)
        else $error("command ran twice");
    a_rx_off: assert property (!o_rx_enable)
        else $error("reception enabled");
    a_ssb_value: assert property (o_slave_status == 8'h80)
        else $error("slave status wrong");
    a_pin_reset: assert property ($fell(i_reset_pin_n) |-> ##[1:4] o_reset_mode)
        else $error("reset pin ignored");
    a_exit_empty: assert property ($fell(o_reset_mode) |-> !o_tx_valid)
        else $error("write fifo not empty on exit");
    c_cmd: cover property (o_cmd_valid);
    c_exit: cover property ($fell(o_reset_mode));
    c_read: cover property (!i_cs_n && o_so_oe);
endmodule
bind shi_top shi_top_sva u_sva (.i_clk_sys, .i_rst_n, .i_cs_n, .i_cd, .i_rw, .i_reset_pin_n,
    .o_so_oe, .i_bus_standby, .o_tx_valid, .o_cmd_valid, .o_reset_mode, .o_rx_enable,
    .o_slave_status);

/* File: tb/shi_top_tb.sv */
// self-checking bench for the serial host interface
`timescale 1ns/1ps
module shi_top_tb;
    import shi_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       sck, si, cs_n, cd, rw, rpin_n, so, rx_ready, tx_valid, cmd_valid, rmode, rx_en;
    logic       rx_valid = 1'b0;
    logic       tx_pop = 1'b0;
    logic       standby = 1'b0;
    logic       irq_ev = 1'b0;
    logic       ret_valid = 1'b0;
    logic       irq = 1'b0;
    logic [3:0] ret_code = 4'h0;
    logic [3:0] ret = 4'h0;
    logic [7:0] rx_data = 8'h00;
    logic [7:0] tx_data, q, d;
    logic [3:0] cmd_code;
    logic [7:0] wq[$], rq[$];
    int         n_fail, checks_done, n_cmd, nw, nr;
    always #25 clk = ~clk;
    shi_top uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_sck(sck), .i_si(si), .i_cs_n(cs_n),
        .i_cd(cd), .i_rw(rw), .i_reset_pin_n(rpin_n), .o_so(so), .o_so_oe(),
        .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_rx_ready(rx_ready), .i_tx_pop(tx_pop),
        .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_bus_standby(standby),
        .i_irq_event(irq_ev), .i_ret_valid(ret_valid), .i_ret_code(ret_code),
        .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code), .o_reset_mode(rmode),
        .o_rx_enable(rx_en), .o_slave_status());
    shi_host_model host (.i_so(so), .o_sck(sck), .o_si(si), .o_cs_n(cs_n), .o_cd(cd),
        .o_rw(rw), .o_reset_pin_n(rpin_n));
    always @(posedge clk) if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] st_exp();
        return {nw == WF_DEPTH, nr == 0, nw == 0, irq, ret};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic xf(input logic c, input logic r, input logic [7:0] v);
        host.xfer(c, r, v, q);
    endtask
    // status read also clears the pending interrupt
    task automatic st();
        xf(1'b1, 1'b1, 8'h00);
        chk(q, st_exp());
        irq = 1'b0;
    endtask
    task automatic wait_cmd(input int n);
        for (int k = 0; k < 100 && n_cmd < n; k++) cyc(1);
        chk(8'(n_cmd), 8'(n));
        if (n_cmd < n) report_and_stop();
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'hb456));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        cyc(3);
        chk({7'h0, rmode}, 8'h01);
        // exit command with the pin still low must not leave reset mode
        xf(1'b1, 1'b0, 8'h00);
        chk({7'h0, rmode}, 8'h01);
        host.pin(1'b1);
        cyc(6);
        chk({7'h0, rmode}, 8'h01);
        xf(1'b1, 1'b0, 8'h00);
        chk({6'h0, rmode, rx_en}, 8'h00);
        st();
        $display("test reset_exit done");
        // five writes into four places: the last is dropped
        for (int i = 0; i < 5; i++) begin
            d = 8'($urandom);
            xf(1'b0, 1'b0, d);
            if (nw < 4) begin
                wq.push_back(d);
                nw++;
            end
        end
        st();
        while (nw > 0) begin
            chk({7'h0, tx_valid}, 8'h01);
            chk(tx_data, wq.pop_front());
            @(posedge clk) tx_pop <= 1'b1;
            @(posedge clk) tx_pop <= 1'b0;
            nw--;
            cyc(2);
        end
        chk({7'h0, tx_valid}, 8'h00);
        st();
        for (int i = 0; i < 21; i++) begin
            d = 8'($urandom);
            @(posedge clk) rx_valid <= 1'b1;
            rx_data <= d;
            if (i < 20) rq.push_back(d);
        end
        @(posedge clk) rx_valid <= 1'b0;
        nr = 20;
        cyc(1);
        chk({7'h0, rx_ready}, 8'h00);
        st();
        while (rq.size() > 0) begin
            xf(1'b0, 1'b1, 8'($urandom));
            chk(q, rq.pop_front());
        end
        nr = 0;
        d = 8'($urandom);
        @(posedge clk) {irq_ev, ret_valid, ret_code} <= {2'h3, d[3:0]};
        @(posedge clk) {irq_ev, ret_valid} <= 2'h0;
        cyc(2);
        {irq, ret} = {1'b1, d[3:0]};
        st();
        st();
        $display("test fifo_status done");
        // a qualified command waits for the idle bus
        xf(1'b1, 1'b0, 8'h4a);
        cyc(20);
        chk(8'(n_cmd), 8'h00);
        @(posedge clk) standby <= 1'b1;
        wait_cmd(1);
        chk({4'h0, cmd_code}, 8'h0a);
        for (int c = 0; c < 16; c++) begin
            xf(1'b1, 1'b0, {4'h4, 4'(c)});
            wait_cmd(c + 2);
            chk({4'h0, cmd_code}, 8'(c));
        end
        xf(1'b1, 1'b0, 8'h07);
        cyc(20);
        chk(8'(n_cmd), 8'h11);
        $display("test commands done");
        // one software-selected byte, then pins govern again
        xf(1'b1, 1'b0, 8'h10);
        d = 8'($urandom);
        xf(1'b1, 1'b0, d);
        nw = 1;
        xf(1'b1, 1'b0, 8'h30);
        xf(1'b1, 1'b0, 8'h00);
        chk(q, st_exp());
        chk(tx_data, d);
        d = 8'($urandom);
        @(posedge clk) rx_valid <= 1'b1;
        rx_data <= d;
        @(posedge clk) rx_valid <= 1'b0;
        xf(1'b1, 1'b0, 8'h20);
        xf(1'b1, 1'b0, 8'h00);
        chk(q, d);
        $display("test soft_modes done");
        xf(1'b1, 1'b0, 8'h80);
        chk({7'h0, rmode}, 8'h01);
        xf(1'b0, 1'b0, 8'($urandom));
        xf(1'b1, 1'b0, 8'h00);
        nw = 0;
        chk({6'h0, rmode, tx_valid}, 8'h00);
        host.pin(1'b0);
        cyc(6);
        chk({7'h0, rmode}, 8'h01);
        host.pin(1'b1);
        cyc(6);
        xf(1'b1, 1'b0, 8'h00);
        chk({7'h0, rmode}, 8'h00);
        $display("test reset_modes done");
        report_and_stop();
    end
endmodule
